// [hw/acc_core.sv]
// converter control: sleep handling, clock divisor, successive approximation sequence
`timescale 1ns/100ps
`default_nettype none
`include "acc_consts.svh"

// Behaviour
// [RL1] no conversion progress while in sleep
// [RL2] sleep clears start/done and enable bits
// [RL3] sleep abort keeps partial result register
// [RL4] sleep entry forces clock and channel selects
// [RL5] wake/reset sets defaults, clears go, enable
// [RL6] software keeps bit period within window
// [RL7] bit period equals source period times divisor
// [RL8] software picks internal clock when needed
// [RL9] writing zero control disables, pins digital
// [RL10] channel change deferred until conversion ends
// [RL11] completion clears go, sets done flag
// [RL12] clock-select code to divisor mapping
// [RL13] go ignored while enable is clear
// [RL14] software reconfigures after wake before start
module acc_core
#(
  parameter int unsigned RESULT_W = 8
)
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 sleep_i,
  input  wire logic                 wake_i,
  input  wire logic                 rc_tick_i,
  input  wire logic                 ctrl_we_i,
  input  wire acc_pkg::acc_ctrl_t   ctrl_wdata_i,
  input  wire logic                 analog_we_i,
  input  wire logic [7:0]           analog_wdata_i,
  input  wire logic                 cmp_bit_i,
  input  wire logic                 done_flag_clr_i,
  output var acc_pkg::acc_ctrl_t    ctrl_o,
  output logic [7:0]                pin_analog_select_o,
  output logic [7:0]                pin_digital_o,
  output logic [3:0]                active_channel_o,
  output logic [RESULT_W-1:0]       conversion_result_o,
  output logic                      conversion_done_flag_o,
  output logic                      sample_bit_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  acc_pkg::acc_ctrl_t  ctrl_q;
  acc_pkg::acc_state_t state_q;
  logic [7:0]          analog_q;
  logic [3:0]          chan_q;
  logic [RESULT_W-1:0] result_q;
  logic [RESULT_W-1:0] marker_q;
  logic [3:0]          step_q;
  logic [4:0]          tick_cnt_q;
  logic                flag_q;
  logic                asleep_q;
  logic                cmp_meta_q;
  logic                cmp_sync_q;
  logic                rc_meta_q;
  logic                rc_sync_q;
  logic                rc_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  wire logic       use_rc    = (ctrl_q.conv_clock_select == `ACC_CS_RC4);
  wire logic       rc_edge   = rc_sync_q & ~rc_prev_q;
  wire logic       src_tick  = use_rc ? rc_edge : 1'b1;
  wire logic [4:0] divisor   = (ctrl_q.conv_clock_select == `ACC_CS_DIV16) ? `ACC_DIV16 :   // RL12
                               (ctrl_q.conv_clock_select == `ACC_CS_DIV8)  ? `ACC_DIV8  :
                                                                              `ACC_DIV4;
  wire logic       bit_tick  = src_tick && (tick_cnt_q == divisor - 5'h01);              // RL7
  wire logic       sleep_hit = sleep_i & ~asleep_q;
  wire logic       running   = (state_q == acc_pkg::ACC_CONVERT);
  wire logic       last_step = bit_tick && (step_q == `ACC_CONV_STEPS - 4'h1);
  wire logic       start_ok  = ctrl_we_i && ctrl_wdata_i.go && ctrl_wdata_i.converter_enable
                               && !running;                                                 // RL13
  wire logic       sw_abort  = ctrl_we_i && running
                               && !(ctrl_wdata_i.go && ctrl_wdata_i.converter_enable);
  // a write keeping go and enable set on the final bit period must not swallow the completion
  wire logic       finish    = running && last_step;                                        // RL11
  wire logic       keep_go   = running && !finish && ctrl_wdata_i.go && ctrl_wdata_i.converter_enable;
  wire logic       step_go   = running && bit_tick && !asleep_q && !sleep_i;                // RL1

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for the comparator result and the internal rc clock

  always_ff @(posedge clk_i)
  begin
    cmp_meta_q <= cmp_bit_i;
    cmp_sync_q <= cmp_meta_q;
    rc_meta_q  <= rc_tick_i;
    rc_sync_q  <= rc_meta_q;
    rc_prev_q  <= rc_sync_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register, sleep and wake

  always_ff @(posedge clk_i)
  begin
    if (rst_i || (wake_i && asleep_q))
    begin
      ctrl_q   <= `ACC_RST_CTRL;                                    // RL5
      analog_q <= `ACC_RST_ANALOG;                                  // RL5
      asleep_q <= 1'b0;
    end
    else if (sleep_hit)
    begin
      ctrl_q.conv_clock_select    <= `ACC_RST_CLKSEL;               // RL4
      ctrl_q.input_channel_select <= `ACC_RST_CHSEL;                // RL4
      ctrl_q.go                   <= 1'b0;                          // RL2
      ctrl_q.converter_enable     <= 1'b0;                          // RL2
      asleep_q                    <= 1'b1;
    end
    else if (!asleep_q)
    begin
      if (ctrl_we_i)
      begin
        ctrl_q    <= ctrl_wdata_i;                                  // RL9
        ctrl_q.go <= start_ok || keep_go;                           // RL13
      end
      else if (finish)
        ctrl_q.go <= 1'b0;                                          // RL11
      if (analog_we_i)
        analog_q <= analog_wdata_i;
      else if (ctrl_we_i && ctrl_wdata_i == '0)
        analog_q <= 8'h00;                                          // RL9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequence: clear, then a marker walks right as bits resolve

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q    <= acc_pkg::ACC_IDLE;
      step_q     <= 4'h0;
      tick_cnt_q <= 5'h00;
      marker_q   <= '0;
      chan_q     <= `ACC_RST_CHSEL;
      flag_q     <= 1'b0;
      result_q   <= '0;
    end
    else
    begin
      if (done_flag_clr_i)
        flag_q <= 1'b0;
      case (state_q)
        acc_pkg::ACC_IDLE:
        begin
          tick_cnt_q <= 5'h00;
          step_q     <= 4'h0;
          if (!ctrl_q.go)
            chan_q <= ctrl_q.input_channel_select;
          if (start_ok && !sleep_i && !asleep_q)
          begin
            state_q <= acc_pkg::ACC_CONVERT;
            chan_q  <= ctrl_wdata_i.input_channel_select;
          end
        end
        acc_pkg::ACC_CONVERT:
        begin
          if (sleep_hit || sw_abort)
            state_q <= acc_pkg::ACC_IDLE;                           // RL3
          else if (step_go)
          begin
            tick_cnt_q <= 5'h00;
            step_q     <= step_q + 4'h1;
            if (step_q == 4'h0)
            begin
              result_q <= '0;
              marker_q <= {1'b1, {(RESULT_W-1){1'b0}}};
            end
            else
            begin
              result_q <= result_q | (cmp_sync_q ? marker_q : '0);
              marker_q <= marker_q >> 1;
            end
            if (finish)
            begin
              state_q <= acc_pkg::ACC_IDLE;
              flag_q  <= 1'b1;                                      // RL11
            end
          end
          else if (src_tick && !asleep_q)
            tick_cnt_q <= tick_cnt_q + 5'h01;
        end
        default:
          state_q <= acc_pkg::ACC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all registered

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_o                 <= `ACC_RST_CTRL;
      pin_analog_select_o    <= `ACC_RST_ANALOG;
      pin_digital_o          <= 8'h00;
      active_channel_o       <= `ACC_RST_CHSEL;
      conversion_result_o    <= '0;
      conversion_done_flag_o <= 1'b0;
      sample_bit_o           <= 1'b0;
    end
    else
    begin
      ctrl_o                 <= ctrl_q;
      pin_analog_select_o    <= analog_q;
      pin_digital_o          <= ~analog_q;
      active_channel_o       <= chan_q;                             // RL10
      conversion_result_o    <= result_q;
      conversion_done_flag_o <= flag_q;
      sample_bit_o           <= step_go && (step_q != 4'h0);
    end
  end

endmodule
`default_nettype wire

// [inc/acc_consts.svh]
// constants for the converter sleep and clock control block
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH

// control register bit positions
`define ACC_BIT_CLKSEL_HI   7
`define ACC_BIT_CLKSEL_LO   6
`define ACC_BIT_CHSEL_HI    5
`define ACC_BIT_CHSEL_LO    2
`define ACC_BIT_GO          1
`define ACC_BIT_EN          0

// reset values
`define ACC_RST_CTRL        8'hfc
`define ACC_RST_ANALOG      8'hff
`define ACC_RST_CLKSEL      2'h3
`define ACC_RST_CHSEL       4'hf

// clock-select codes
`define ACC_CS_DIV16        2'h0
`define ACC_CS_DIV8         2'h1
`define ACC_CS_DIV4         2'h2
`define ACC_CS_RC4          2'h3

// divisors, in source clock ticks per bit period
`define ACC_DIV16           5'h10
`define ACC_DIV8            5'h08
`define ACC_DIV4            5'h04

// bit periods per conversion: one clear step plus eight resolved bits
`define ACC_CONV_STEPS      4'h9

// accurate bit period window, in ns
`define ACC_TAD_MIN_NS      500
`define ACC_TAD_MAX_NS      50000

`endif

// [inc/acc_pkg.sv]
// types for the converter sleep and clock control block
package acc_pkg;

  typedef struct packed {
    logic [1:0] conv_clock_select;
    logic [3:0] input_channel_select;
    logic       go;
    logic       converter_enable;
  } acc_ctrl_t;

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_CONVERT
  } acc_state_t;

endpackage

// [tb/acc_core_monitor.sv]
// checker for the converter sleep and clock control block
`timescale 1ns/100ps
`default_nettype none
module acc_core_monitor (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               sleep_i,
  input wire logic               ctrl_we_i,
  input wire logic               analog_we_i,
  input wire acc_pkg::acc_ctrl_t ctrl_wdata_i,
  input wire acc_pkg::acc_ctrl_t ctrl_o,
  input wire logic [7:0]         pin_analog_select_o,
  input wire logic [7:0]         pin_digital_o,
  input wire logic [7:0]         conversion_result_o,
  input wire logic               conversion_done_flag_o,
  input wire logic               sample_bit_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  // three cycles asleep: the one-cycle output lag has drained by then
  sequence s_asleep;
    sleep_i [*3];
  endsequence
  sequence s_zero_write;
    // a same-cycle pin-select write takes precedence over the zero write
    ctrl_we_i && ctrl_wdata_i == 8'h00 && !sleep_i && !analog_we_i;
  endsequence
  chk_reset_defaults: assert property ($fell(rst_i) |-> ctrl_o == 8'hfc && pin_analog_select_o == 8'hff
    && !conversion_done_flag_o) else $error("defaults wrong after reset");
  chk_pins_inverse: assert property (pin_digital_o == ~pin_analog_select_o)
    else $error("digital pins not inverse of analog select");
  chk_go_needs_en: assert property (ctrl_o.go |-> ctrl_o.converter_enable)
    else $error("go set while converter disabled");
  chk_go_ignored: assert property (ctrl_we_i && !ctrl_wdata_i.converter_enable |-> ##2 !ctrl_o.go)
    else $error("go accepted from a write with enable clear");
  chk_sleep_entry: assert property ($rose(sleep_i) |-> ##2 ctrl_o == 8'hfc)
    else $error("sleep entry did not force control defaults");
  chk_sleep_result: assert property (s_asleep |-> $stable(conversion_result_o))
    else $error("result moved during sleep");
  chk_sleep_idle: assert property (s_asleep |-> !sample_bit_o)
    else $error("bit resolved during sleep");
  chk_zero_off: assert property (s_zero_write |-> ##2 pin_analog_select_o == 8'h00)
    else $error("zero write left pins analog");
  chk_done_go: assert property ($rose(conversion_done_flag_o) |-> ##[0:1] !ctrl_o.go)
    else $error("go still set after completion");
  chk_div4_step: assert property (sample_bit_o && ctrl_o.conv_clock_select == 2'h2
    |=> !sample_bit_o [*3]) else $error("bit period shorter than four clocks");
endmodule
bind acc_core acc_core_monitor u_mon (.clk_i, .rst_i, .sleep_i, .ctrl_we_i, .analog_we_i, .ctrl_wdata_i, .ctrl_o,
  .pin_analog_select_o, .pin_digital_o, .conversion_result_o, .conversion_done_flag_o, .sample_bit_o);
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the converter sleep and clock control block
`timescale 1ns/100ps
`default_nettype none
`include "acc_consts.svh"
module testbench;
  logic               clk = 0, rst = 1, slp = 0, wk = 0, rc = 0, we = 0, awe = 0, cmp = 0, clr = 0;
  acc_pkg::acc_ctrl_t wd = 8'h00, co;
  logic [7:0]         ad = 8'h00, ap, pd, res, r;
  logic [3:0]         ach;
  logic               fl, sb;
  int                 fail_count = 0, num_checks = 0, n, sbn, cyc = 0, q[$];
  localparam int      RC_NS = 220;
  always #12.5 clk = ~clk;
  // rc source runs unrelated to clk
  always #(RC_NS / 2) rc = ~rc;
  // pulses counted mid-cycle, away from the edge that launches them
  always @(negedge clk) if (sb === 1'b1) sbn++;
  always @(posedge clk) cyc++;
  acc_core u_dut (.clk_i(clk), .rst_i(rst), .sleep_i(slp), .wake_i(wk), .rc_tick_i(rc), .ctrl_we_i(we),
    .ctrl_wdata_i(wd), .analog_we_i(awe), .analog_wdata_i(ad), .cmp_bit_i(cmp), .done_flag_clr_i(clr),
    .ctrl_o(co), .pin_analog_select_o(ap), .pin_digital_o(pd), .active_channel_o(ach),
    .conversion_result_o(res), .conversion_done_flag_o(fl), .sample_bit_o(sb));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(logic [7:0] g, logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wr(logic [7:0] v);
    @(negedge clk) wd = v; we = 1;
    @(negedge clk) we = 0;
  endtask
  task automatic start(logic [1:0] cs, logic [3:0] ch);
    cmp = 1'($urandom);
    q.push_back(cmp ? 255 : 0);
    sbn = 0;
    wr({cs, ch, 2'h3});
    n = cyc;
  endtask
  // polls completion; cycles run from the start write, whatever the caller did meanwhile
  task automatic finish(logic [1:0] cs, logic [3:0] ch);
    while (fl !== 1'b1 && cyc - n < 2000)
      tick(1);
    n = cyc - n;
    chk({7'h0, fl}, 8'h01);
    if (cs != 2'h3) chk(8'(n >= 9 * (16 >> cs) && n <= 9 * (16 >> cs) + 4), 8'h01);
    if (cs == 2'h3) chk(8'(n * 25 > 32 * RC_NS && n * 25 < 40 * RC_NS), 8'h01);
    if (cs == 2'h3) chk(8'(n * 25 / 9 > `ACC_TAD_MIN_NS && n * 25 / 9 < `ACC_TAD_MAX_NS), 8'h01);
    tick(1);
    chk(res, 8'(q.pop_front()));
    chk(co, {cs, ch, 2'h1});
    chk(8'(sbn), 8'h08);
    @(negedge clk) clr = 1;
    @(negedge clk) clr = 0;
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // far beyond the roughly one thousand cycles the sequence needs
  initial
  begin
    #2000000;
    fail_count++;
    print_verdict;
  end
  initial
  begin
    void'($urandom(75829));
    tick(3);
    rst = 0;
    tick(1);
    chk(co, 8'hfc); chk(ap, 8'hff); chk(pd, 8'h00); chk(res, 8'h00); chk({3'h0, fl, ach}, 8'h0f);
    for (int cs = 0; cs < 4; cs++)
    begin
      start(2'(cs), 4'h3);
      finish(2'(cs), 4'h3);
    end
    wr(8'hf2); tick(2); chk(co, 8'hf0);
    // channel change mid-conversion must wait for the end
    start(2'h2, 4'h3); tick(4); wr({2'h2, 4'h5, 2'h3}); tick(3); chk({4'h0, ach}, 8'h03);
    finish(2'h2, 4'h5); tick(2); chk({4'h0, ach}, 8'h05);
    ad = 8'h0f;
    @(negedge clk) awe = 1;
    @(negedge clk) awe = 0;
    // sleep lands after two resolved bits of a divide-by-16 conversion
    start(2'h0, 4'h1); tick(60);
    slp = 1; tick(3); r = res; chk(co, 8'hfc); chk(ap, 8'h0f);
    chk(r, 8'(q.pop_back()) & 8'hc0);
    wr(8'h07); tick(6); chk(co, 8'hfc); chk(res, r); chk({7'h0, fl}, 8'h00);
    @(negedge clk) wk = 1;
    @(negedge clk) wk = 0; slp = 0;
    tick(3); chk(co, 8'hfc); chk(ap, 8'hff); chk(res, r);
    // settings were forced to defaults: reselect everything, on the rc clock
    start(2'h3, 4'h2);
    finish(2'h3, 4'h2);
    wr(8'h00); tick(2); chk(co, 8'h00); chk(ap, 8'h00); chk(pd, 8'hff);
    print_verdict;
  end
endmodule
`default_nettype wire
